//--- core/room_climate_param_regs.sv
`timescale 1ns/10ps
module room_climate_param_regs (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Register access from the field bus engine
	input wire logic [7:0] reg_index,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_wdata,
	output logic [31:0] reg_rdata,
	output logic reg_rvalid,
	output logic reg_err,
	// Room hardware
	// Live values are taken as synchronous to clk
	input wire room_climate_pkg::live_in_t live,
	// Regulation settings
	output room_climate_pkg::ctrl_out_t ctrl
);

	room_climate_pkg::state_t s_q; // Registered state
	room_climate_pkg::state_t s_d; // Next state
	// Combinational helpers feeding the next-state logic
	logic signed [31:0] wval; // Write value as signed
	logic window_open; // Polarity-corrected window state
	logic signed [15:0] offset_used; // Offset after mode gating
	logic [15:0] actual; // Selected room temperature
	logic [6:0] ball_level; // Larger of the two demands under its limit
	logic [15:0] live_temp; // Sensor reading clipped to range

	// Inclusive signed range check shared by every writable field except sensor and mode select
	// Limits are ints so negative offsets compare correctly
	function automatic logic in_range(input logic signed [31:0] v,
		input int lo, input int hi);
		in_range = (v >= lo) && (v <= hi);
	endfunction : in_range

	// Demand limited by a percent limit
	// Limits never exceed 100, so the low seven bits suffice
	function automatic logic [6:0] limit_pct(input logic [6:0] dem,
		input logic [15:0] lim);
		limit_pct = ({9'h000, dem} > lim) ? lim[6:0] : dem;
	endfunction : limit_pct

	// Zero-extension of a 16-bit field to a bus word
	function automatic logic [31:0] zx(input logic [15:0] v);
		zx = {16'h0000, v};
	endfunction : zx

	// Write data is signed two's complement
	assign wval = reg_wdata;

	// Derived values, all combinational from live inputs and registered state
	// The clip comes first: an always_comb does not wake on its own
	// results, so a later read of live_temp would lag one event
	always_comb begin
		// Clip sensor so software never sees more than full scale
		if (live.sensor_temp > 16'(room_climate_pkg::TEMP_MAX)) begin
			live_temp = 16'(room_climate_pkg::TEMP_MAX);
		end else begin
			live_temp = live.sensor_temp;
		end
		// Contact meaning follows the configured polarity
		window_open = live.window_contact_input ^ s_q.window_pol;
		// Bus-sourced room value replaces the local sensor
		actual = (s_q.sensor_sel == room_climate_pkg::SENSOR_BUS) ?
			s_q.bus_temp : live_temp;
		// Offset only shifts the set-point in comfort or standby
		if ((live.op_mode == room_climate_pkg::OPMODE_COMFORT) ||
			(live.op_mode == room_climate_pkg::OPMODE_STANDBY)) begin
			offset_used = s_q.sp_offset;
		end else begin
			offset_used = 16'sh0000;
		end
		// Ball valve follows the larger demand under its own limit
		ball_level = (live.heat_demand > live.cool_demand) ?
			limit_pct(live.heat_demand, s_q.heat_lim_now) :
			limit_pct(live.cool_demand, s_q.cool_lim_now);
	end

	// Next-state: bus writes, read capture and exported settings
	always_comb begin
		s_d = s_q;
		s_d.rvalid = 1'b0;
		s_d.err = 1'b0;
		// Refused writes pulse reg_err and never clamp: a clamped value
		// would hide a station fault behind a changed setting
		// Ranges: run-down 0..24, comfort zone 0..200, other zones 10..200, bands 5..100,
		// integral times 0..1000, set-points 100..350, limits 0..100
		// Working set-point has no default of its own; restart copies
		// the base value into it
		// Writes: a value outside its range leaves the field as it was
		if (reg_wr) begin
			case (reg_index)
				room_climate_pkg::IDX_COMFORT_RUNDOWN: begin
					if (in_range(wval, 0, room_climate_pkg::RUNDOWN_MAX))
						s_d.rundown = wval[15:0];
					else s_d.err = 1'b1;
				end
				room_climate_pkg::IDX_NZ_COMFORT: begin
					if (in_range(wval, room_climate_pkg::NZ_COMFORT_MIN,
						room_climate_pkg::NZ_MAX))
						s_d.nz_comfort = wval[15:0];
					else s_d.err = 1'b1;
				end
				room_climate_pkg::IDX_NZ_STANDBY: begin
					if (in_range(wval, room_climate_pkg::NZ_OTHER_MIN,
						room_climate_pkg::NZ_MAX))
						s_d.nz_standby = wval[15:0];
					else s_d.err = 1'b1;
				end
				room_climate_pkg::IDX_NZ_REDUCED: begin
					if (in_range(wval, room_climate_pkg::NZ_OTHER_MIN,
						room_climate_pkg::NZ_MAX))
						s_d.nz_reduced = wval[15:0];
					else s_d.err = 1'b1;
				end
				room_climate_pkg::IDX_PB_COOL: begin
					if (in_range(wval, room_climate_pkg::PB_MIN,
						room_climate_pkg::PB_MAX))
						s_d.pb_cool = wval[15:0];
					else s_d.err = 1'b1;
				end
				room_climate_pkg::IDX_PB_HEAT: begin
					if (in_range(wval, room_climate_pkg::PB_MIN,
						room_climate_pkg::PB_MAX))
						s_d.pb_heat = wval[15:0];
					else s_d.err = 1'b1;
				end
				room_climate_pkg::IDX_TI_COOL: begin
					if (in_range(wval, 0, room_climate_pkg::TI_MAX))
						s_d.ti_cool = wval[15:0];
					else s_d.err = 1'b1;
				end
				room_climate_pkg::IDX_TI_HEAT: begin
					if (in_range(wval, 0, room_climate_pkg::TI_MAX))
						s_d.ti_heat = wval[15:0];
					else s_d.err = 1'b1;
				end
				room_climate_pkg::IDX_SENSOR_SELECT: begin
					if ((wval == 32'sd1) || (wval == 32'sd2))
						s_d.sensor_sel = wval[15:0];
					else s_d.err = 1'b1;
				end
				room_climate_pkg::IDX_BUS_ROOM_TEMP: begin
					// Station supplies the room value in bus mode
					if (in_range(wval, 0, room_climate_pkg::TEMP_MAX))
						s_d.bus_temp = wval[15:0];
					else s_d.err = 1'b1;
				end
				room_climate_pkg::IDX_MODE_SELECT: begin
					// Unused codes 2 and 4 are refused
					case (wval)
						32'sd0, 32'sd1, 32'sd3, 32'sd5, 32'sd6, 32'sd10:
							s_d.mode_sel =
								room_climate_pkg::ctrl_mode_t'(wval[3:0]);
						default: s_d.err = 1'b1;
					endcase
				end
				room_climate_pkg::IDX_SP_OFFSET: begin
					if (in_range(wval, room_climate_pkg::OFFSET_MIN,
						room_climate_pkg::OFFSET_MAX))
						s_d.sp_offset = wval[15:0];
					else s_d.err = 1'b1;
				end
				room_climate_pkg::IDX_BASE_SP: begin
					if (in_range(wval, room_climate_pkg::SP_MIN,
						room_climate_pkg::SP_MAX))
						s_d.base_sp = wval[15:0];
					else s_d.err = 1'b1;
				end
				room_climate_pkg::IDX_WORKING_SP: begin
					if (in_range(wval, room_climate_pkg::SP_MIN,
						room_climate_pkg::SP_MAX))
						s_d.working_sp = wval[15:0];
					else s_d.err = 1'b1;
				end
				room_climate_pkg::IDX_OUTPUT_CFG: begin
					if (in_range(wval, 0, room_climate_pkg::OUTCFG_MAX))
						s_d.output_cfg = wval[15:0];
					else s_d.err = 1'b1;
				end
				room_climate_pkg::IDX_WINDOW_POL: begin
					if (in_range(wval, 0, 1))
						s_d.window_pol = wval[0];
					else s_d.err = 1'b1;
				end
				room_climate_pkg::IDX_COOL_LIM_CFG: begin
					if (in_range(wval, 0, room_climate_pkg::PCT_MAX))
						s_d.cool_lim_cfg = wval[15:0];
					else s_d.err = 1'b1;
				end
				room_climate_pkg::IDX_HEAT_LIM_CFG: begin
					if (in_range(wval, 0, room_climate_pkg::PCT_MAX))
						s_d.heat_lim_cfg = wval[15:0];
					else s_d.err = 1'b1;
				end
				room_climate_pkg::IDX_COOL_LIM_NOW: begin
					if (in_range(wval, 0, room_climate_pkg::PCT_MAX))
						s_d.cool_lim_now = wval[15:0];
					else s_d.err = 1'b1;
				end
				room_climate_pkg::IDX_HEAT_LIM_NOW: begin
					if (in_range(wval, 0, room_climate_pkg::PCT_MAX))
						s_d.heat_lim_now = wval[15:0];
					else s_d.err = 1'b1;
				end
				// Read-only or unmapped indices refuse writes
				default: s_d.err = 1'b1;
			endcase
		end else if (reg_rd) begin
			// Live inputs are sampled on the request edge, so the
			// station sees a contact or sensor as it stood then
			// Offset and manual adjustment are sign-extended; every
			// other field is zero-extended to the bus word
			// A write in the same cycle wins and the read is dropped
			// Unmapped reads return zero with an error pulse
			// Reads: answer registered one cycle later
			s_d.rvalid = 1'b1;
			case (reg_index)
				room_climate_pkg::IDX_COMFORT_RUNDOWN: s_d.rdata = zx(s_q.rundown);
				room_climate_pkg::IDX_NZ_COMFORT: s_d.rdata = zx(s_q.nz_comfort);
				room_climate_pkg::IDX_NZ_STANDBY: s_d.rdata = zx(s_q.nz_standby);
				room_climate_pkg::IDX_NZ_REDUCED: s_d.rdata = zx(s_q.nz_reduced);
				room_climate_pkg::IDX_PB_COOL: s_d.rdata = zx(s_q.pb_cool);
				room_climate_pkg::IDX_PB_HEAT: s_d.rdata = zx(s_q.pb_heat);
				room_climate_pkg::IDX_TI_COOL: s_d.rdata = zx(s_q.ti_cool);
				room_climate_pkg::IDX_TI_HEAT: s_d.rdata = zx(s_q.ti_heat);
				room_climate_pkg::IDX_SENSOR_SELECT:
					s_d.rdata = zx(s_q.sensor_sel);
				room_climate_pkg::IDX_MANUAL_ADJ:
					s_d.rdata = {{24{live.manual_adjust[7]}}, live.manual_adjust};
				room_climate_pkg::IDX_PRESENCE:
					s_d.rdata = {31'h00000000, ~live.presence_detected};
				room_climate_pkg::IDX_BUS_ROOM_TEMP: s_d.rdata = zx(s_q.bus_temp);
				room_climate_pkg::IDX_MODE_SELECT:
					s_d.rdata = {28'h0000000, s_q.mode_sel};
				room_climate_pkg::IDX_SP_OFFSET: // Sign-extended
					s_d.rdata = {{16{s_q.sp_offset[15]}}, s_q.sp_offset};
				room_climate_pkg::IDX_BASE_SP: s_d.rdata = zx(s_q.base_sp);
				room_climate_pkg::IDX_WORKING_SP: s_d.rdata = zx(s_q.working_sp);
				room_climate_pkg::IDX_EFF_ACTUAL:
					s_d.rdata = zx(s_q.ctrl.eff_actual);
				room_climate_pkg::IDX_CUR_MODE:
					s_d.rdata = {28'h0000000, s_q.ctrl.cur_mode};
				room_climate_pkg::IDX_WINDOW_RAW:
					s_d.rdata = {31'h00000000, live.window_contact_input};
				room_climate_pkg::IDX_EFF_SP:
					s_d.rdata = zx(s_q.ctrl.eff_setpoint);
				room_climate_pkg::IDX_AUX_RAW:
					s_d.rdata = {31'h00000000, live.auxiliary_contact_input};
				room_climate_pkg::IDX_SENSOR_TEMP: s_d.rdata = zx(live_temp);
				room_climate_pkg::IDX_AUX_VOLT:
					s_d.rdata = zx(live.auxiliary_voltage_input);
				room_climate_pkg::IDX_OUTPUT_CFG: s_d.rdata = zx(s_q.output_cfg);
				room_climate_pkg::IDX_WINDOW_POL:
					s_d.rdata = {31'h00000000, s_q.window_pol};
				room_climate_pkg::IDX_COOL_LIM_CFG:
					s_d.rdata = zx(s_q.cool_lim_cfg);
				room_climate_pkg::IDX_HEAT_LIM_CFG:
					s_d.rdata = zx(s_q.heat_lim_cfg);
				room_climate_pkg::IDX_COOL_LIM_NOW:
					s_d.rdata = zx(s_q.cool_lim_now);
				room_climate_pkg::IDX_HEAT_LIM_NOW:
					s_d.rdata = zx(s_q.heat_lim_now);
				// Unmapped index: zero data with error flag
				default: begin
					s_d.rdata = 32'h00000000;
					s_d.err = 1'b1;
				end
			endcase
		end
		// The control copy lags the register state by one clock; the
		// regulation logic sees only registered values, which keeps
		// bus timing out of its input paths
		// Settings for the regulation logic, refreshed every cycle
		s_d.ctrl.comfort_rundown = s_q.rundown;
		s_d.ctrl.nz_comfort = s_q.nz_comfort;
		s_d.ctrl.nz_standby = s_q.nz_standby;
		s_d.ctrl.nz_reduced = s_q.nz_reduced;
		s_d.ctrl.pb_cool = s_q.pb_cool;
		s_d.ctrl.pb_heat = s_q.pb_heat;
		s_d.ctrl.ti_cool = s_q.ti_cool;
		s_d.ctrl.ti_heat = s_q.ti_heat;
		// Integral terms switch off when their time is zero
		s_d.ctrl.int_cool_en = (s_q.ti_cool != 16'h0000);
		s_d.ctrl.int_heat_en = (s_q.ti_heat != 16'h0000);
		// Polarity-corrected window state for the regulation
		s_d.ctrl.window_open = window_open;
		// An open window forces frost protection over the selection
		s_d.ctrl.cur_mode = window_open ?
			room_climate_pkg::MODE_FROST : s_q.mode_sel;
		// Effective actual value follows the selected source
		s_d.ctrl.eff_actual = actual;
		// Offset is already zero outside comfort and standby
		s_d.ctrl.eff_setpoint =
			16'($signed(s_q.working_sp) + offset_used);
		// Regulation is capped by the current, writable limits
		s_d.ctrl.heating_valve_limit = s_q.heat_lim_now;
		s_d.ctrl.cooling_valve_limit = s_q.cool_lim_now;
		// Third output carries the ball valve only in that mode
		s_d.ctrl.ball_valve_mode =
			(s_q.output_cfg == room_climate_pkg::OUTCFG_BALL_VALVE);
		s_d.ctrl.third_analogue_output =
			s_d.ctrl.ball_valve_mode ? ball_level : 7'h00;
	end

	// State register; restart reloads every parameter default
	// Reset clears the read answer and the control copy first, then
	// loads each parameter default; the later assignments win
	// Base default lies below its write range: a station must write
	// a valid base before relying on it
	// Working set-point takes the same default, so after a restart
	// it equals the base set-point
	always_ff @(posedge clk) begin
		if (srst) begin
			s_q <= '0;
			s_q.rundown <= room_climate_pkg::RST_RUNDOWN;
			s_q.nz_comfort <= room_climate_pkg::RST_NZ_COMFORT;
			s_q.nz_standby <= room_climate_pkg::RST_NZ_STANDBY;
			s_q.nz_reduced <= room_climate_pkg::RST_NZ_REDUCED;
			s_q.pb_cool <= room_climate_pkg::RST_PB;
			s_q.pb_heat <= room_climate_pkg::RST_PB;
			s_q.ti_cool <= room_climate_pkg::RST_TI;
			s_q.ti_heat <= room_climate_pkg::RST_TI;
			s_q.sensor_sel <= room_climate_pkg::RST_SENSOR_SEL;
			s_q.bus_temp <= room_climate_pkg::RST_BUS_TEMP;
			s_q.mode_sel <= room_climate_pkg::MODE_AUTO;
			s_q.sp_offset <= room_climate_pkg::RST_SP_OFFSET;
			s_q.base_sp <= room_climate_pkg::RST_BASE_SP;
			s_q.working_sp <= room_climate_pkg::RST_BASE_SP;
			s_q.output_cfg <= room_climate_pkg::RST_OUTPUT_CFG;
			s_q.window_pol <= room_climate_pkg::RST_WINDOW_POL;
			s_q.cool_lim_cfg <= room_climate_pkg::RST_VALVE_LIM;
			s_q.heat_lim_cfg <= room_climate_pkg::RST_VALVE_LIM;
			s_q.cool_lim_now <= room_climate_pkg::RST_VALVE_LIM;
			s_q.heat_lim_now <= room_climate_pkg::RST_VALVE_LIM;
		end else begin
			s_q <= s_d;
		end
	end

	// Read data holds until the next read; valid and error are
	// single-cycle pulses that the station must catch at once
	// Control settings are registered like every other output
	// Outputs straight from flip-flops
	assign reg_rdata = s_q.rdata;
	assign reg_rvalid = s_q.rvalid;
	assign reg_err = s_q.err;
	assign ctrl = s_q.ctrl;

endmodule : room_climate_param_regs

//--- core/room_climate_pkg.sv
package room_climate_pkg;

	// Register indices as numbered on the field bus
	localparam logic [7:0] IDX_COMFORT_RUNDOWN = 8'h00;
	localparam logic [7:0] IDX_NZ_COMFORT = 8'h02;
	localparam logic [7:0] IDX_NZ_STANDBY = 8'h03;
	localparam logic [7:0] IDX_NZ_REDUCED = 8'h04;
	localparam logic [7:0] IDX_PB_COOL = 8'h05;
	localparam logic [7:0] IDX_PB_HEAT = 8'h06;
	localparam logic [7:0] IDX_TI_COOL = 8'h07;
	localparam logic [7:0] IDX_SENSOR_SELECT = 8'h0D;
	localparam logic [7:0] IDX_MANUAL_ADJ = 8'h15;
	localparam logic [7:0] IDX_PRESENCE = 8'h16;
	localparam logic [7:0] IDX_BUS_ROOM_TEMP = 8'h1E;
	localparam logic [7:0] IDX_MODE_SELECT = 8'h1F;
	localparam logic [7:0] IDX_SP_OFFSET = 8'h22;
	localparam logic [7:0] IDX_BASE_SP = 8'h25;
	localparam logic [7:0] IDX_WORKING_SP = 8'h29;
	localparam logic [7:0] IDX_EFF_ACTUAL = 8'h32;
	localparam logic [7:0] IDX_CUR_MODE = 8'h33;
	localparam logic [7:0] IDX_WINDOW_RAW = 8'h35;
	localparam logic [7:0] IDX_EFF_SP = 8'h36;
	localparam logic [7:0] IDX_AUX_RAW = 8'h46;
	localparam logic [7:0] IDX_SENSOR_TEMP = 8'h47;
	localparam logic [7:0] IDX_AUX_VOLT = 8'h48;
	localparam logic [7:0] IDX_OUTPUT_CFG = 8'h67;
	localparam logic [7:0] IDX_WINDOW_POL = 8'h69;
	localparam logic [7:0] IDX_TI_HEAT = 8'h6A;
	localparam logic [7:0] IDX_COOL_LIM_CFG = 8'h8C;
	localparam logic [7:0] IDX_HEAT_LIM_CFG = 8'h8D;
	localparam logic [7:0] IDX_COOL_LIM_NOW = 8'h8E;
	localparam logic [7:0] IDX_HEAT_LIM_NOW = 8'h8F;

	// Reset values
	localparam logic [15:0] RST_RUNDOWN = 16'h0000;
	localparam logic [15:0] RST_NZ_COMFORT = 16'h0014;
	localparam logic [15:0] RST_NZ_STANDBY = 16'h0028;
	localparam logic [15:0] RST_NZ_REDUCED = 16'h003C;
	localparam logic [15:0] RST_PB = 16'h0032;
	localparam logic [15:0] RST_TI = 16'h0000;
	localparam logic [15:0] RST_BASE_SP = 16'h0016;
	localparam logic [15:0] RST_VALVE_LIM = 16'h0064;
	localparam logic [15:0] RST_BUS_TEMP = 16'h0000;
	localparam logic [15:0] RST_SP_OFFSET = 16'h0000;
	localparam logic [15:0] RST_SENSOR_SEL = 16'h0001;
	localparam logic [15:0] RST_OUTPUT_CFG = 16'h0000;
	localparam logic RST_WINDOW_POL = 1'b0;

	// Accepted ranges (inclusive)
	localparam int RUNDOWN_MAX = 24;
	localparam int NZ_COMFORT_MIN = 0;
	localparam int NZ_OTHER_MIN = 10;
	localparam int NZ_MAX = 200;
	localparam int PB_MIN = 5;
	localparam int PB_MAX = 100;
	localparam int TI_MAX = 1000;
	localparam int SP_MIN = 100;
	localparam int SP_MAX = 350;
	localparam int OFFSET_MIN = -30;
	localparam int OFFSET_MAX = 30;
	localparam int PCT_MAX = 100;
	localparam int TEMP_MAX = 400;
	localparam int OUTCFG_MAX = 5;

	// Room sensor selection codes
	localparam logic [15:0] SENSOR_LOCAL = 16'h0001;
	localparam logic [15:0] SENSOR_BUS = 16'h0002;

	// Output configuration: single ball valve on the third output
	localparam logic [15:0] OUTCFG_BALL_VALVE = 16'h0005;

	// Operating mode input codes
	localparam logic [1:0] OPMODE_COMFORT = 2'h0;
	localparam logic [1:0] OPMODE_STANDBY = 2'h2;

	// Control mode codes
	typedef enum logic [3:0] {
		MODE_AUTO = 4'h0,
		MODE_HEAT = 4'h1,
		MODE_COOL = 4'h3,
		MODE_FROST = 4'h5,
		MODE_OFF = 4'h6,
		MODE_MANUAL = 4'hA
	} ctrl_mode_t;

	// Live values from the room hardware
	typedef struct packed {
		logic window_contact_input;
		logic auxiliary_contact_input;
		logic presence_detected;
		logic [15:0] sensor_temp;
		logic [15:0] auxiliary_voltage_input;
		logic [7:0] manual_adjust;
		logic [1:0] op_mode;
		logic [6:0] heat_demand;
		logic [6:0] cool_demand;
	} live_in_t;

	// Settings handed to the regulation logic
	typedef struct packed {
		logic [15:0] comfort_rundown;
		logic [15:0] nz_comfort;
		logic [15:0] nz_standby;
		logic [15:0] nz_reduced;
		logic [15:0] pb_cool;
		logic [15:0] pb_heat;
		logic [15:0] ti_cool;
		logic [15:0] ti_heat;
		logic int_cool_en;
		logic int_heat_en;
		logic window_open;
		ctrl_mode_t cur_mode;
		logic [15:0] eff_actual;
		logic [15:0] eff_setpoint;
		logic [15:0] heating_valve_limit;
		logic [15:0] cooling_valve_limit;
		logic ball_valve_mode;
		logic [6:0] third_analogue_output;
	} ctrl_out_t;

	// Whole register state of the bank
	typedef struct packed {
		logic [15:0] rundown;
		logic [15:0] nz_comfort;
		logic [15:0] nz_standby;
		logic [15:0] nz_reduced;
		logic [15:0] pb_cool;
		logic [15:0] pb_heat;
		logic [15:0] ti_cool;
		logic [15:0] ti_heat;
		logic [15:0] sensor_sel;
		logic [15:0] bus_temp;
		ctrl_mode_t mode_sel;
		logic [15:0] sp_offset;
		logic [15:0] base_sp;
		logic [15:0] working_sp;
		logic [15:0] output_cfg;
		logic window_pol;
		logic [15:0] cool_lim_cfg;
		logic [15:0] heat_lim_cfg;
		logic [15:0] cool_lim_now;
		logic [15:0] heat_lim_now;
		logic [31:0] rdata;
		logic rvalid;
		logic err;
		ctrl_out_t ctrl;
	} state_t;

endpackage : room_climate_pkg

//--- verif/room_climate_chk.sv
`timescale 1ns/10ps
module room_climate_chk (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Register port
	input wire logic [7:0] reg_index,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_wdata,
	input wire logic [31:0] reg_rdata,
	input wire logic reg_rvalid,
	input wire logic reg_err,
	// Room side
	input wire room_climate_pkg::live_in_t live,
	input wire room_climate_pkg::ctrl_out_t ctrl
);
	// A read counts only when no write wins over it
	logic rd_ok;
	assign rd_ok = reg_rd && !reg_wr;
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	a_read_answer: assert property (rd_ok |=> reg_rvalid)
		else $error("read not answered");
	a_presence_read: assert property (rd_ok && reg_index == 8'h16 |=>
		reg_rdata == {31'h0, !$past(live.presence_detected)})
		else $error("presence read wrong");
	a_window_raw: assert property (rd_ok && reg_index == 8'h35 |=>
		reg_rdata == {31'h0, $past(live.window_contact_input)})
		else $error("window contact read wrong");
	a_aux_raw: assert property (rd_ok && reg_index == 8'h46 |=>
		reg_rdata == {31'h0, $past(live.auxiliary_contact_input)})
		else $error("aux contact read wrong");
	a_sensor_span: assert property (rd_ok && reg_index == 8'h47 |=>
		reg_rdata <= 32'h190)
		else $error("sensor reading beyond span");
	a_ro_refused: assert property (reg_wr && (reg_index == 8'h36 ||
		reg_index == 8'h33 || reg_index == 8'h32) |=> reg_err)
		else $error("read-only write accepted");
	a_mode_refused: assert property (reg_wr && reg_index == 8'h1F &&
		(reg_wdata == 32'h2 || reg_wdata == 32'h4) |=> reg_err)
		else $error("unused mode code accepted");
	a_band_refused: assert property (reg_wr && reg_index == 8'h06 &&
		($signed(reg_wdata) < 5 || $signed(reg_wdata) > 100)
		|=> reg_err)
		else $error("band write out of range accepted");
	a_int_enable: assert property ((ctrl.int_heat_en ==
		(ctrl.ti_heat != 16'h0)) &&
		(ctrl.int_cool_en == (ctrl.ti_cool != 16'h0)))
		else $error("integral enable wrong");
	a_ball_off: assert property (!ctrl.ball_valve_mode |->
		ctrl.third_analogue_output == 7'h0)
		else $error("third output driven without ball valve");
endmodule : room_climate_chk

bind room_climate_param_regs room_climate_chk chk (.clk(clk),
	.srst(srst), .reg_index(reg_index), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
	.reg_rvalid(reg_rvalid), .reg_err(reg_err), .live(live),
	.ctrl(ctrl));

//--- verif/room_climate_param_regs_bench.sv
`timescale 1ns/10ps
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin \
	num_errors++; $display("CHECK FAILED %s exp %0h seen %0h", \
	n, e, s); end end
module room_climate_param_regs_bench;
	// Clock, reset and wires
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic [7:0] reg_index;
	logic reg_wr, reg_rd, reg_rvalid, reg_err;
	logic [31:0] reg_wdata, reg_rdata, d, w;
	room_climate_pkg::live_in_t live = '0;
	room_climate_pkg::ctrl_out_t ctrl;
	int num_errors = 0;
	int checks = 0;
	// Expected register contents
	logic [31:0] exp_v [256];
	logic [7:0] di [17] = '{8'h00, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06,
		8'h07, 8'h6A, 8'h25, 8'h29, 8'h8C, 8'h8D, 8'h8E, 8'h8F, 8'h1F,
		8'h22, 8'h69};
	logic [7:0] dv [17] = '{8'h00, 8'h14, 8'h28, 8'h3C, 8'h32, 8'h32,
		8'h00, 8'h00, 8'h16, 8'h16, 8'h64, 8'h64, 8'h64, 8'h64, 8'h00,
		8'h00, 8'h00};
	logic [7:0] ri [16] = '{8'h00, 8'h00, 8'h02, 8'h03, 8'h04, 8'h05,
		8'h06, 8'h06, 8'h07, 8'h6A, 8'h25, 8'h25, 8'h8C, 8'h8F, 8'h22,
		8'h22};
	logic [31:0] rv [16] = '{32'h18, 32'h19, 32'h0, 32'h9, 32'hA,
		32'h4, 32'h64, 32'h65, 32'h3E8, 32'h3E9, 32'h15E, 32'h63,
		32'h65, 32'h0, 32'hFFFFFFE1, 32'hFFFFFFE2};
	logic re [16] = '{0, 1, 0, 1, 0, 1, 0, 1, 0, 1, 0, 1, 1, 0, 1, 0};
	logic [7:0] ro [9] = '{8'h16, 8'h32, 8'h33, 8'h35, 8'h36, 8'h46,
		8'h47, 8'h48, 8'h15};
	logic [3:0] mc [6] = '{4'h0, 4'h1, 4'h3, 4'h5, 4'h6, 4'hA};
	int offs [2] = '{20, -30};

	// 50 MHz clock
	always #10 clk = ~clk;

	room_climate_param_regs uut (.clk(clk), .srst(srst),
		.reg_index(reg_index), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .reg_err(reg_err), .live(live),
		.ctrl(ctrl));
	station_model stn (.clk(clk), .reg_index(reg_index),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.reg_err(reg_err));

	// Verdict and end of run
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : wrap_up
	// Write, compare refusal, track what should be stored
	task automatic wchk(input logic [7:0] i, input logic [31:0] x,
		input logic r);
		logic f;
		stn.wr(i, x, f);
		`CHK("reg_err", r, f)
		if (!r) exp_v[i] = x;
	endtask : wchk
	// Read and compare valid flag and data
	task automatic rchk(input logic [7:0] i, input logic [31:0] x);
		logic [31:0] q;
		logic ok;
		stn.rd(i, q, ok);
		`CHK("reg_rvalid", 1'b1, ok)
		`CHK("reg_rdata", x, q)
	endtask : rchk
	// Offset counts only in comfort and standby
	function automatic logic [31:0] sp_exp(input int s, input int o,
		input logic [1:0] m);
		return (m == 2'h0 || m == 2'h2) ? s + o : s;
	endfunction : sp_exp
	// Settle time for values derived through the control copy
	task automatic settle;
		repeat (3) @(negedge clk);
	endtask : settle

	// Hang guard
	initial begin
		#2000000;
		num_errors++;
		wrap_up;
	end

	initial begin
		void'($urandom(89));
		repeat (20) @(posedge clk);
		@(negedge clk);
		srst = 1'b0;
		for (int k = 0; k < 17; k++) begin
			exp_v[di[k]] = {24'h0, dv[k]};
			rchk(di[k], exp_v[di[k]]);
		end
		$display("test defaults done");
		for (int k = 0; k < 16; k++) begin
			wchk(ri[k], rv[k], re[k]);
		end
		for (int k = 0; k < 16; k++) begin
			rchk(ri[k], exp_v[ri[k]]);
		end
		for (int k = 0; k < 9; k++) begin
			wchk(ro[k], 32'h1, 1'b1);
		end
		`CHK("int_cool_en", 1'b1, ctrl.int_cool_en)
		`CHK("int_heat_en", 1'b0, ctrl.int_heat_en)
		`CHK("cool_limit", 16'h64, ctrl.cooling_valve_limit)
		$display("test ranges done");
		for (int k = 0; k < 6; k++) begin
			wchk(8'h1F, {28'h0, mc[k]}, 1'b0);
			settle;
			rchk(8'h33, {28'h0, mc[k]});
		end
		wchk(8'h1F, 32'h2, 1'b1);
		wchk(8'h1F, 32'h4, 1'b1);
		rchk(8'h1F, 32'hA);
		$display("test modes done");
		for (int p = 0; p < 2; p++) begin
			for (int c = 0; c < 2; c++) begin
				wchk(8'h69, p, 1'b0);
				live.window_contact_input = 1'(c);
				settle;
				`CHK("window_open", 1'(c ^ p), ctrl.window_open)
				rchk(8'h35, c);
				rchk(8'h33, (c ^ p) ? 32'h5 : 32'hA);
			end
		end
		live.window_contact_input = 1'b0;
		wchk(8'h69, 32'h0, 1'b0);
		$display("test window done");
		wchk(8'h29, 32'hC8, 1'b0);
		for (int k = 0; k < 2; k++) begin
			wchk(8'h22, offs[k], 1'b0);
			for (int m = 0; m < 3; m++) begin
				live.op_mode = 2'(m);
				settle;
				rchk(8'h36, sp_exp(200, offs[k], 2'(m)));
			end
		end
		$display("test offset done");
		live.sensor_temp = 16'h007B;
		wchk(8'h0D, 32'h2, 1'b0);
		wchk(8'h1E, 32'hFA, 1'b0);
		settle;
		rchk(8'h32, 32'hFA);
		wchk(8'h0D, 32'h1, 1'b0);
		settle;
		rchk(8'h32, 32'h7B);
		live.sensor_temp = 16'h01F4;
		rchk(8'h47, 32'h190);
		$display("test source done");
		live.heat_demand = 7'h3C;
		live.cool_demand = 7'h00;
		wchk(8'h8F, 32'h28, 1'b0);
		wchk(8'h67, 32'h5, 1'b0);
		settle;
		`CHK("heat_limit", 16'h28, ctrl.heating_valve_limit)
		`CHK("ball_valve", 1'b1, ctrl.ball_valve_mode)
		`CHK("third_out", 7'h28, ctrl.third_analogue_output)
		wchk(8'h67, 32'h0, 1'b0);
		settle;
		`CHK("third_out", 7'h00, ctrl.third_analogue_output)
		$display("test ball valve done");
		srst = 1'b1;
		repeat (2) @(negedge clk);
		srst = 1'b0;
		rchk(8'h29, 32'h16);
		rchk(8'h25, 32'h16);
		$display("test restart done");
		repeat (20) begin
			live.presence_detected = 1'($urandom);
			live.window_contact_input = 1'($urandom);
			live.auxiliary_contact_input = 1'($urandom);
			live.sensor_temp = 16'($urandom_range(400));
			live.auxiliary_voltage_input = 16'($urandom_range(1000));
			live.manual_adjust = 8'($urandom);
			rchk(8'h16, {31'h0, ~live.presence_detected});
			rchk(8'h35, {31'h0, live.window_contact_input});
			rchk(8'h46, {31'h0, live.auxiliary_contact_input});
			rchk(8'h47, {16'h0, live.sensor_temp});
			rchk(8'h48, {16'h0, live.auxiliary_voltage_input});
			d = {{24{live.manual_adjust[7]}}, live.manual_adjust};
			rchk(8'h15, d);
			w = 32'($urandom_range(100, 5));
			wchk(8'h06, w, 1'b0);
			rchk(8'h06, w);
		end
		$display("test random done");
		wrap_up;
	end
endmodule : room_climate_param_regs_bench

//--- verif/station_model.sv
`timescale 1ns/10ps
module station_model (
	// Clock
	input wire logic clk,
	// Requests towards the bank
	output logic [7:0] reg_index,
	output logic reg_wr,
	output logic reg_rd,
	output logic [31:0] reg_wdata,
	// Answers from the bank
	input wire logic [31:0] reg_rdata,
	input wire logic reg_rvalid,
	input wire logic reg_err
);
	// Idle bus at time zero
	initial begin
		reg_index = 8'hFF;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = 32'h0;
	end
	// Stale lines are inverted so leftovers never look like a request
	task automatic wr(input logic [7:0] i, input logic [31:0] d,
		output logic e);
		@(negedge clk);
		reg_index <= i;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(negedge clk);
		reg_wr <= 1'b0;
		reg_index <= ~i;
		reg_wdata <= ~d;
		e = reg_err;
	endtask : wr
	// Answer stands one cycle, so it is taken at the next falling edge
	task automatic rd(input logic [7:0] i, output logic [31:0] d,
		output logic v);
		@(negedge clk);
		reg_index <= i;
		reg_rd <= 1'b1;
		@(negedge clk);
		reg_rd <= 1'b0;
		reg_index <= ~i;
		d = reg_rdata;
		v = reg_rvalid;
	endtask : rd
endmodule : station_model
